// [core/rsg_port.sv]
// Serial gateway port: APB registers, UART, framing timers, slave filter, gateway sequencer.
// Assumes APB master on clk; the line transceiver enable is driven here on tx_en.
`timescale 1ns/10ps
`include "rsg_params.svh"
module rsg_port import rsg_pkg::*; #(
	parameter int CLK_HZ       = `RSG_CLK_HZ,
	parameter int MS_CYCLES    = CLK_HZ / 1000,
	parameter int TENTH_CYCLES = CLK_HZ / 10
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial line
	input  wire logic        rxd,
	output logic             txd,
	output logic             tx_en,
	// Frame events
	output logic             frame_start,
	output logic             frame_end
);
	// Configuration
	logic             mode_gw;
	rsg_proto_e       proto;
	rsg_baud_e        baud;
	rsg_par_e         par;
	logic [7:0]       serial_port_unit_identifier;
	logic             bcast_en;
	logic [3:0]       tmo_sel;
	logic [3:0]       gap_sel;
	logic [3:0]       ext_sel;
	// UART state
	logic [15:0]      bit_cycles;
	logic [3:0]       char_bits;
	logic [15:0]      tx_cnt;
	logic [3:0]       tx_idx;
	logic [11:0]      tx_shift;
	logic             tx_busy;
	logic [15:0]      rx_cnt;
	logic [3:0]       rx_idx;
	logic [10:0]      rx_shift;
	logic             rx_busy;
	logic             rx_done;
	logic [7:0]       rx_byte;
	logic             rx_perr;
	// Framing
	logic [23:0]      idle_cnt;
	logic             in_frame;
	logic             first_char;
	logic             drop_frame;
	logic             addr_drop;
	logic [23:0]      rx_chars;
	logic             rx_push;
	logic             buf_ready;
	logic             buf_valid;
	logic [7:0]       buf_data;
	logic             buf_pop;
	// Gateway
	rsg_gw_e          gw_state;
	logic [31:0]      gw_timer;
	logic             tx_req;
	logic [7:0]       tx_byte;
	logic             excpt;
	logic             wr_en;
	logic             rd_en;
	logic             apb_hit;
	logic [31:0]      next_prdata;

	// Cycles per bit for a baud selection
	function automatic logic [15:0] baud_div(input rsg_baud_e b);
		unique case (b)
			RSG_B9600:  baud_div = 16'(CLK_HZ / 9600);
			RSG_B38400: baud_div = 16'(CLK_HZ / 38400);
			default:    baud_div = 16'(CLK_HZ / 19200);
		endcase
	endfunction

	// Parity of a data word with the configured sense
	function automatic logic par_bit(input logic [7:0] d, input logic seven, input rsg_par_e p);
		logic x;
		x = seven ? ^d[6:0] : ^d;
		par_bit = (p == RSG_PODD) ? ~x : x;
	endfunction

	assign bit_cycles = baud_div(baud);
	assign char_bits  = 4'd2 + ((proto == RSG_ASCII7) ? 4'd7 : 4'd8)
	                    + ((par == RSG_PNONE) ? 4'd0 : 4'd1);

	// APB access strobes
	assign apb_hit = psel && penable;
	assign wr_en   = apb_hit && pwrite;
	assign rd_en   = apb_hit && !pwrite;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_gw                     <= 1'b0;
			proto                       <= RSG_RTU;
			baud                        <= RSG_B19200;
			par                         <= RSG_PEVEN;
			serial_port_unit_identifier <= `RSG_RST_ADDR;
		end else if (wr_en && paddr == `RSG_OFF_CFG) begin
			// Mode select; gateway never runs with ASCII
			if (!(pwdata[`RSG_CFG_MODE_BIT] && pwdata[`RSG_CFG_PROTO_LSB+1])) begin
				mode_gw <= pwdata[`RSG_CFG_MODE_BIT];
				proto   <= rsg_proto_e'(pwdata[`RSG_CFG_PROTO_LSB+:2]);
			end
			if (pwdata[`RSG_CFG_BAUD_LSB+:2] != 2'h3)
				baud <= rsg_baud_e'(pwdata[`RSG_CFG_BAUD_LSB+:2]);
			if (pwdata[`RSG_CFG_PAR_LSB+:2] != 2'h3)
				par <= rsg_par_e'(pwdata[`RSG_CFG_PAR_LSB+:2]);
			if ((pwdata[`RSG_CFG_ADDR_LSB+:8] != 8'h00
			     && pwdata[`RSG_CFG_ADDR_LSB+:8] <= `RSG_ADDR_MAX)
			    || pwdata[`RSG_CFG_ADDR_LSB+:8] == `RSG_VARIANT_ID)
				serial_port_unit_identifier <= pwdata[`RSG_CFG_ADDR_LSB+:8];
		end
	end

	// Gateway advanced settings
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bcast_en <= 1'b0;
			tmo_sel  <= 4'h0;
			gap_sel  <= 4'h0;
			ext_sel  <= 4'h0;
		end else if (wr_en && paddr == `RSG_OFF_GWCFG) begin
			bcast_en <= pwdata[`RSG_GW_BCAST_BIT];
			if (pwdata[`RSG_GW_TMO_LSB+:4] != 4'hF)
				tmo_sel <= pwdata[`RSG_GW_TMO_LSB+:4];
			if (pwdata[`RSG_GW_GAP_LSB+:4] <= `RSG_GAP_MAX_STEPS)
				gap_sel <= pwdata[`RSG_GW_GAP_LSB+:4];
			ext_sel <= pwdata[`RSG_GW_EXT_LSB+:4];
		end
	end

	// Read mux, zero-wait answer
	always_comb begin
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			`RSG_OFF_CFG:    next_prdata = {16'h0000, serial_port_unit_identifier, 1'b0,
			                                 par, baud, proto, mode_gw};
			`RSG_OFF_GWCFG:  next_prdata = {16'h0000, ext_sel, gap_sel, tmo_sel, 3'h0, bcast_en};
			`RSG_OFF_STATUS: next_prdata = {24'h000000, !buf_ready, gw_state, excpt, rx_perr,
			                                 tx_busy, buf_valid};
			`RSG_OFF_RXDATA: next_prdata = {24'h000000, buf_data};
			default:         next_prdata = 32'h0000_0000;
		endcase
	end

	// APB answer flops; unmapped address flags an error
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			prdata  <= next_prdata;
			pslverr <= psel && !penable && paddr != `RSG_OFF_CFG && paddr != `RSG_OFF_GWCFG
			           && paddr != `RSG_OFF_STATUS && paddr != `RSG_OFF_TXDATA
			           && paddr != `RSG_OFF_RXDATA && `RSG_ERR_UNMAPPED;
		end
	end

	// Read of the data register drains the buffer
	assign buf_pop = rd_en && pready && paddr == `RSG_OFF_RXDATA;

	// Software words; gateway drops a broadcast request in idle unless enabled
	always_comb begin
		tx_byte = pwdata[7:0];
		tx_req  = wr_en && pready && paddr == `RSG_OFF_TXDATA;
		if (mode_gw && gw_state == RSG_IDLE && tx_byte == 8'h00 && !bcast_en)
			tx_req = 1'b0;
	end

	// Transmitter, 7 or 8 data bits, parity dropped when none
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_busy  <= 1'b0;
			tx_cnt   <= 16'h0000;
			tx_idx   <= 4'h0;
			tx_shift <= 12'hFFF;
			txd      <= 1'b1;
			tx_en    <= 1'b0;
		end else if (!tx_busy) begin
			txd   <= 1'b1;
			tx_en <= 1'b0;
			if (tx_req && (gw_state != RSG_GAP)) begin
				tx_busy  <= 1'b1;
				tx_cnt   <= 16'h0000;
				tx_idx   <= 4'h0;
				tx_en    <= 1'b1;
				if (proto == RSG_ASCII7)
					tx_shift <= {3'b111, (par != RSG_PNONE) ? par_bit(tx_byte, 1'b1, par)
					             : 1'b1, tx_byte[6:0], 1'b0};
				else
					tx_shift <= {2'b11, (par != RSG_PNONE) ? par_bit(tx_byte, 1'b0, par)
					             : 1'b1, tx_byte, 1'b0};
			end
		end else begin
			txd <= tx_shift[0];
			if (tx_cnt == bit_cycles - 16'h1) begin
				tx_cnt   <= 16'h0000;
				tx_shift <= {1'b1, tx_shift[11:1]};
				tx_idx   <= tx_idx + 4'h1;
				if (tx_idx == char_bits - 4'h1)
					tx_busy <= 1'b0;
			end else begin
				tx_cnt <= tx_cnt + 16'h1;
			end
		end
	end

	// Receiver, samples mid-bit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_busy  <= 1'b0;
			rx_cnt   <= 16'h0000;
			rx_idx   <= 4'h0;
			rx_shift <= 11'h000;
			rx_done  <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (!rx_busy) begin
				if (!rxd) begin
					rx_busy <= 1'b1;
					rx_cnt  <= {1'b0, bit_cycles[15:1]};
					rx_idx  <= 4'h0;
				end
			end else if (rx_cnt == bit_cycles - 16'h1) begin
				rx_cnt   <= 16'h0000;
				rx_shift <= {rxd, rx_shift[10:1]};
				rx_idx   <= rx_idx + 4'h1;
				if (rx_idx == char_bits - 4'h1) begin
					rx_busy <= 1'b0;
					rx_done <= 1'b1;
				end
			end else begin
				rx_cnt <= rx_cnt + 16'h1;
			end
		end
	end

	// Align received bits by format; stop bit is top
	always_comb begin
		rx_byte = (proto == RSG_ASCII7) ? {1'b0, rx_shift[11-char_bits+1 +: 7]}
		                                : rx_shift[11-char_bits+1 +: 8];
		rx_perr = (par != RSG_PNONE) && (rx_shift[9] != par_bit(rx_byte, proto == RSG_ASCII7, par));
	end

	// Silence counter in cycles, extended by whole characters
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_cnt  <= 24'h000000;
			in_frame  <= 1'b0;
			frame_end <= 1'b0;
		end else begin
			frame_end <= 1'b0;
			if (rx_busy || rx_done) begin
				idle_cnt <= 24'h000000;
				in_frame <= 1'b1;
			end else if (in_frame) begin
				idle_cnt <= idle_cnt + 24'h1;
				if (idle_cnt >= 24'(rx_chars) * (24'd7 + 24'(ext_sel) * 24'd2) / 24'd2) begin
					in_frame  <= 1'b0;
					frame_end <= 1'b1;
				end
			end
		end
	end

	// Cycles per character
	assign rx_chars = 24'(bit_cycles) * 24'(char_bits);

	// First character of a new frame
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_char  <= 1'b1;
			frame_start <= 1'b0;
			drop_frame  <= 1'b0;
		end else begin
			frame_start <= 1'b0;
			if (frame_end)
				first_char <= 1'b1;
			else if (rx_done) begin
				first_char <= 1'b0;
				if (first_char) begin
					frame_start <= 1'b1;
					drop_frame <= addr_drop;
				end
			end
		end
	end

	// Slave address filter; gateway broadcast gate
	assign addr_drop = mode_gw ? (rx_byte == 8'h00 && !bcast_en)
	                           : (rx_byte != serial_port_unit_identifier && rx_byte != 8'h00);
	// Accepted characters enter the buffer; a full one drops them, status shows it
	assign rx_push = rx_done && !rx_perr && !(first_char ? addr_drop : drop_frame);

	rsg_buf2 #(
		.WIDTH(8)
	) u_buf (
		.clk      (clk),
		.rstn     (rstn),
		.in_valid (rx_push),
		.in_ready (buf_ready),
		.in_data  (rx_byte),
		.out_valid(buf_valid),
		.out_ready(buf_pop),
		.out_data (buf_data)
	);

	// Gateway sequencer: gap, send, wait, exception
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gw_state <= RSG_IDLE;
			gw_timer <= 32'h0;
			excpt    <= 1'b0;
		end else begin
			// Status read clears; a timeout in the same cycle still sets
			if (rd_en && pready && paddr == `RSG_OFF_STATUS)
				excpt <= 1'b0;
			unique case (gw_state)
				RSG_IDLE: if (mode_gw && tx_busy) gw_state <= RSG_SEND;
				RSG_SEND: if (!tx_busy) begin
					gw_state <= RSG_WAIT;
					gw_timer <= 32'h0;
				end
				RSG_WAIT: begin
					gw_timer <= gw_timer + 32'h1;
					if (frame_end) begin
						gw_state <= RSG_GAP;
						gw_timer <= 32'h0;
					end else if (gw_timer >= 32'(TENTH_CYCLES) * (tmo_sel < 4'h5 ?
					             32'(tmo_sel) + 32'h1 : (32'(tmo_sel) - 32'h4) * 32'd10)) begin
						gw_state <= RSG_EXCPT;
						excpt    <= 1'b1;
					end
				end
				RSG_EXCPT: gw_state <= RSG_IDLE;
				RSG_GAP: begin
					gw_timer <= gw_timer + 32'h1;
					if (gw_timer >= 32'(MS_CYCLES) * 32'(`RSG_GAP_STEP_MS) * 32'(gap_sel))
						gw_state <= RSG_IDLE;
				end
				default: gw_state <= RSG_IDLE;
			endcase
		end
	end
endmodule

// [core/rsg_params.svh]
// Constants of the serial gateway port: register map, field layout, reset values, timing.
// Assumes an APB slave with 32-bit data and a 250 MHz clock.
`ifndef RSG_PARAMS_SVH
`define RSG_PARAMS_SVH

// Register byte offsets
`define RSG_OFF_CFG        12'h000
`define RSG_OFF_GWCFG      12'h004
`define RSG_OFF_STATUS     12'h008
`define RSG_OFF_TXDATA     12'h00C
`define RSG_OFF_RXDATA     12'h010

// Configuration fields
`define RSG_CFG_MODE_BIT   0
`define RSG_CFG_PROTO_LSB  1
`define RSG_CFG_BAUD_LSB   3
`define RSG_CFG_PAR_LSB    5
`define RSG_CFG_ADDR_LSB   8
`define RSG_GW_BCAST_BIT   0
`define RSG_GW_TMO_LSB     4
`define RSG_GW_GAP_LSB     8
`define RSG_GW_EXT_LSB     12

// Reset address and address limits
`define RSG_RST_ADDR       8'h01
`define RSG_ADDR_MAX       8'hF7
`define RSG_VARIANT_ID     8'hFF

// Timing and error policy
`define RSG_CLK_HZ         250000000
`define RSG_GAP_STEP_MS    10
`define RSG_GAP_MAX_STEPS  4'hA
`define RSG_TMO_STEPS      15
`define RSG_EXT_MAX        15
`define RSG_ERR_UNMAPPED   1'b1

`endif

// [core/rsg_pkg.sv]
// Types of the serial gateway port.
// Assumes rsg_params.svh is on the include path.
package rsg_pkg;
	typedef enum logic [1:0] {RSG_SLAVE = 2'h0, RSG_GATEWAY = 2'h1} rsg_mode_e;
	typedef enum logic [1:0] {
		RSG_RTU = 2'h0, RSG_VARIANT = 2'h1, RSG_ASCII8 = 2'h2, RSG_ASCII7 = 2'h3
	} rsg_proto_e;
	typedef enum logic [1:0] {
		RSG_B9600 = 2'h0, RSG_B19200 = 2'h1, RSG_B38400 = 2'h2
	} rsg_baud_e;
	typedef enum logic [1:0] {RSG_PEVEN = 2'h0, RSG_PODD = 2'h1, RSG_PNONE = 2'h2} rsg_par_e;
	typedef enum logic [2:0] {
		RSG_IDLE  = 3'h0,
		RSG_SEND  = 3'h1,
		RSG_WAIT  = 3'h3,
		RSG_GAP   = 3'h2,
		RSG_EXCPT = 3'h7
	} rsg_gw_e;
endpackage

// [core/rsg_buf2.sv]
// Two-entry valid/ready buffer for received words.
// Assumes one clock; source and sink follow valid/ready handshake.
`timescale 1ns/10ps
module rsg_buf2 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	logic [WIDTH-1:0] mem [2];
	logic             wr_ptr;
	logic             rd_ptr;
	logic [1:0]       count;
	logic             push;
	logic             pop;

	// Handshake terms
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];

	// Storage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem[0] <= '0;
			mem[1] <= '0;
		end else if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push && !pop)
				count <= count + 2'h1;
			else if (pop && !push)
				count <= count - 2'h1;
		end
	end
endmodule

// [testbench/rsg_port_props.sv]
// Checker for rsg_port: APB answer timing, transmit framing, frame events.
// Assumes one clock domain; bound to every rsg_port instance.
`timescale 1ns/10ps
module rsg_port_props #(
	parameter int CLK_HZ = 153600
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// APB handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Serial line and events
	input wire logic rxd,
	input wire logic txd,
	input wire logic tx_en,
	input wire logic frame_start,
	input wire logic frame_end
);
	// Floor of three shortest characters; exact figure depends on format
	localparam int MIN_Q = (CLK_HZ / 38400) * 27;
	logic [15:0] quiet;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Run of line-high cycles; saturates so it never wraps
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			quiet <= 16'h0000;
		end else if (!rxd) begin
			quiet <= 16'h0000;
		end else if (quiet != 16'hFFFF) begin
			quiet <= quiet + 16'h0001;
		end
	end
	// APB steps
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && pready; endsequence
	property p_zero_wait; s_setup |=> s_access; endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("pready late");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
	property p_err_pair; pslverr |-> s_access; endproperty
	a_err_pair: assert property (p_err_pair) else $error("pslverr alone");
	property p_idle_high; !tx_en |-> txd; endproperty
	a_idle_high: assert property (p_idle_high) else $error("line low idle");
	property p_start_bit; $rose(tx_en) |-> ##[0:2] !txd; endproperty
	a_start_bit: assert property (p_start_bit) else $error("no start bit");
	property p_min_char; $rose(tx_en) |=> tx_en [*8]; endproperty
	a_min_char: assert property (p_min_char) else $error("char too short");
	property p_silence; frame_end |-> quiet >= MIN_Q; endproperty
	a_silence: assert property (p_silence) else $error("frame end early");
	property p_end_pulse; frame_end |=> !frame_end; endproperty
	a_end_pulse: assert property (p_end_pulse) else $error("end held");
	property p_start_pulse; frame_start |=> !frame_start && !frame_end; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start held");
endmodule

bind rsg_port rsg_port_props #(.CLK_HZ(CLK_HZ)) u_props (
	.clk, .rstn, .psel, .penable, .pready, .pslverr,
	.rxd, .txd, .tx_en, .frame_start, .frame_end
);

// [testbench/rsg_line_model.sv]
// Far-side serial node: drives the device's receive line, decodes its transmit line.
// Assumes the same rate and format as the device; the bus idles high.
`timescale 1ns/10ps
module rsg_line_model (
	// Clock and lines
	input  wire logic clk,
	input  wire logic txd,
	output logic      rxd
);
	initial begin
		rxd = 1'b1;
	end
	task automatic send_char(input logic [7:0] d, input int bc, input int nd, input int y);
		bit q[$];
		q = {1'b0};
		for (int i = 0; i < nd; i++) begin
			q.push_back(d[i]);
		end
		if (y != 2) begin
			q.push_back((^(d & (8'hFF >> (8 - nd)))) ^ (y == 1));
		end
		q.push_back(1'b1);
		foreach (q[i]) begin
			rxd <= q[i];
			repeat (bc) @(posedge clk);
		end
	endtask
	// Samples mid-bit; returns data then the bit after it
	task automatic recv_char(input int bc, input int nd, output logic [8:0] v);
		int n;
		n = 0;
		v = 9'h1FF;
		while (txd !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		repeat (bc / 2) @(posedge clk);
		for (int i = 0; i <= nd; i++) begin
			repeat (bc) @(posedge clk);
			v[i] = txd;
		end
	endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for rsg_port: registers over APB, traffic through a line model.
// Assumes shortened timers: 4 to 16 cycles per bit, 0.1 s as 1000 cycles.
`timescale 1ns/10ps
`include "rsg_params.svh"
module tb;
	localparam int HZ = 153600;
	logic        clk, rstn, psel, penable, pwrite, rxd, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, txd, tx_en, frame_start, frame_end;
	int          n_mismatch, num_checks, seed;

	rsg_port #(.CLK_HZ(HZ), .MS_CYCLES(100), .TENTH_CYCLES(1000)) dut (
		.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rxd, .txd, .tx_en, .frame_start, .frame_end
	);
	rsg_line_model node (.clk, .txd, .rxd);

	// Free-running 4 ns clock
	always #2 clk = ~clk;

	task automatic report_and_stop();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	// One APB transfer; an edge passes first so psel is never set twice at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) begin
			chk("pready", 1, 0);
			report_and_stop();
		end
		r = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string s);
		apb(1'b0, a, 32'h0);
		chk(s, e, r);
	endtask
	function automatic logic [31:0] cfgw(int m, int p, int b, int y, int a);
		return {16'h0000, a[7:0], 1'b0, y[1:0], b[1:0], p[1:0], m[0]};
	endfunction
	// Expected data bits, then parity or stop bit
	function automatic logic [8:0] frm(logic [7:0] d, int nd, int y);
		logic [8:0] e;
		e = 9'h1FF;
		for (int i = 0; i < nd; i++) begin
			e[i] = d[i];
		end
		e[nd] = (y == 2) ? 1'b1 : ((^(d & (8'hFF >> (8 - nd)))) ^ (y == 1));
		return e;
	endfunction

	initial begin
		logic [31:0] bad [4];
		logic [31:0] w;
		logic [7:0]  d;
		logic [8:0]  v;
		int          b, y, p, a, g, e, nd;
		seed = 47696;
		n_mismatch = 0;
		num_checks = 0;
		{clk, rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rdc(`RSG_OFF_CFG, cfgw(0, 0, 1, 0, 1), "cfg reset");
		rdc(`RSG_OFF_GWCFG, 32'h0, "gwcfg reset");
		rdc(12'h014, 32'h0, "unmapped");
		chk("slverr", 1, rerr);
		// Refused field values leave the word unchanged
		bad = '{cfgw(0, 0, 3, 0, 1), cfgw(0, 0, 1, 3, 1), cfgw(0, 0, 1, 0, 0), cfgw(0, 0, 1, 0, 248)};
		foreach (bad[i]) begin
			apb(1'b1, `RSG_OFF_CFG, bad[i]);
			rdc(`RSG_OFF_CFG, cfgw(0, 0, 1, 0, 1), "cfg bad");
		end
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 247 : 1 + $unsigned($random(seed)) % 247;
			p = $unsigned($random(seed)) % 4;
			a = (p == 1) ? 255 : a;
			w = cfgw(0, p, i % 3, (i + 1) % 3, a);
			apb(1'b1, `RSG_OFF_CFG, w);
			rdc(`RSG_OFF_CFG, w, "cfg legal");
		end
		// ASCII framing refused while forwarding
		for (p = 2; p < 4; p++) begin
			apb(1'b1, `RSG_OFF_CFG, cfgw(1, 1, 2, 2, 5));
			apb(1'b1, `RSG_OFF_CFG, cfgw(1, p, 2, 2, 5));
			rdc(`RSG_OFF_CFG, cfgw(1, 1, 2, 2, 5), "gw proto");
		end
		// Every rate against every parity, random format
		for (int i = 0; i < 9; i++) begin
			b = i % 3;
			y = i / 3;
			p = $unsigned($random(seed)) % 4;
			nd = (p == 3) ? 7 : 8;
			d = 8'($random(seed));
			apb(1'b1, `RSG_OFF_CFG, cfgw(0, p, b, y, (p == 1) ? 255 : 9));
			fork
				apb(1'b1, `RSG_OFF_TXDATA, {24'h0, d});
				node.recv_char(16 >> b, nd, v);
			join
			chk("tx char", {23'h0, frm(d, nd, y)}, {23'h0, v});
			repeat (40) @(posedge clk);
		end
		// Slave filter: own, own with long silence, foreign, broadcast
		apb(1'b1, `RSG_OFF_CFG, cfgw(0, 0, 2, 2, 8'h2C));
		for (int i = 0; i < 4; i++) begin
			a = (i == 2) ? 8'h2D : (i == 3) ? 0 : 8'h2C;
			apb(1'b1, `RSG_OFF_GWCFG, (i == 1) ? 32'hF000 : 32'h0);
			d = 8'($random(seed));
			node.send_char(a[7:0], 4, 8, 2);
			node.send_char(d, 4, 8, 2);
			g = 0;
			while (frame_end !== 1'b1 && g < 2000) begin
				@(posedge clk);
				g++;
			end
			e = (i == 1) ? 740 : 140;
			chk("silence", 1, (g >= e - 40) && (g <= e + 40));
			repeat (4) @(posedge clk);
			apb(1'b0, `RSG_OFF_STATUS, 32'h0);
			chk("rx valid", (i != 2), r[0]);
			if (i != 2) begin
				rdc(`RSG_OFF_RXDATA, a, "rx addr");
				rdc(`RSG_OFF_RXDATA, {24'h0, d}, "rx data");
			end
		end
		// Gateway: a reply, then a request inside the 10 ms gap is dropped
		apb(1'b1, `RSG_OFF_CFG, cfgw(1, 0, 2, 2, 1));
		apb(1'b1, `RSG_OFF_GWCFG, 32'h100);
		fork
			apb(1'b1, `RSG_OFF_TXDATA, 32'h22);
			node.recv_char(4, 8, v);
		join
		node.send_char(8'h22, 4, 8, 2);
		g = 0;
		while (frame_end !== 1'b1 && g < 2000) begin
			@(posedge clk);
			g++;
		end
		chk("reply end", 1, frame_end);
		apb(1'b1, `RSG_OFF_TXDATA, 32'h33);
		g = 0;
		repeat (200) begin
			@(posedge clk);
			g += tx_en;
		end
		chk("gap hold", 0, g);
		repeat (1000) @(posedge clk);
		// Unanswered request times out
		fork
			apb(1'b1, `RSG_OFF_TXDATA, 32'h11);
			node.recv_char(4, 8, v);
		join
		chk("fwd", 32'h111, {23'h0, v});
		repeat (700) @(posedge clk);
		apb(1'b0, `RSG_OFF_STATUS, 32'h0);
		chk("early tmo", 0, r[3]);
		g = 0;
		while (r[3] !== 1'b1 && g < 100) begin
			repeat (10) @(posedge clk);
			apb(1'b0, `RSG_OFF_STATUS, 32'h0);
			g++;
		end
		chk("tmo", 1, r[3]);
		repeat (200) @(posedge clk);
		// Broadcast dropped, then forwarded once enabled
		apb(1'b1, `RSG_OFF_TXDATA, 32'h0);
		g = 0;
		repeat (200) begin
			@(posedge clk);
			g += tx_en;
		end
		chk("bcast off", 0, g);
		apb(1'b1, `RSG_OFF_GWCFG, 32'h1);
		fork
			apb(1'b1, `RSG_OFF_TXDATA, 32'h0);
			node.recv_char(4, 8, v);
		join
		chk("bcast on", 32'h100, {23'h0, v});
		report_and_stop();
	end
endmodule
